// [hw/pin_share_pkg.sv]
/*
 * constants and carrier types for the shared peripheral-port / arbiter pin group.
 * assumes a single core clock domain and an internal access sequencer upstream.
 */
package pin_share_pkg;
    localparam int STRAP_BIT       = 7;   // mode strap position on the sdram address pins
    localparam int SDRAM_ADDR_W    = 13;
    localparam int ADDR_W          = 32;
    localparam int DATA_W          = 32;
    localparam int NUM_CS          = 3;
    localparam int NUM_EXT_MASTERS = 4;
    localparam int NUM_MASTERS     = NUM_EXT_MASTERS + 1;
    localparam int PME_STATUS_BIT  = 15;
    localparam int PME_ENABLE_BIT  = 8;
    localparam int PMCS_W          = 16;
    localparam int PME_CS_INDEX    = 1;
    // chip-select windows: address bits [25:24] pick the peripheral
    localparam int CS_SEL_LSB      = 24;
    localparam logic [1:0] CS_SEL_RESET = 2'h0;
    localparam logic       STRAP_RESET  = 1'h1;  // pull-up default: peripheral port

    typedef enum logic [1:0] {
        PORT_IDLE,
        PORT_READ,
        PORT_WRITE
    } port_state_type;

    // one peripheral access request from the processor side
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              wide;     // 1: 16-bit peripheral, 0: 8-bit
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } port_req_type;

    // pin-level drive of the shared group
    typedef struct packed {
        logic              buf_dir_n;
        logic              rd_n;
        logic              wr_n;
        logic              gnt0_n;
        logic [NUM_CS-1:0] cs_out_n;
        logic [NUM_CS-1:0] cs_oe_n;
    } pin_drive_type;
endpackage

// [hw/xbus_arbiter_pin_share.sv]
/*
 * shared pin group: parallel peripheral port or pci arbiter pins, selected by a strap.
 * assumes external transceivers on the data bus and a board link from request to grant.
 */
`timescale 1ns/1ps

// What this block does
// - strap bit seven high gives peripheral port, low gives arbiter pins
// - strap pins sampled once, on the first clock after reset release, then held
// - 8 and 16-bit peripherals, address and data on processor buses
// - buffer direction low for the whole of every write, high otherwise
// - read strobe low during a peripheral read
// - write strobe low during a peripheral write
// - output chip selects assert the one matching the accessed address range
// - unused chip-select pins serve as interrupt inputs, direction per control bit
// - chip select one as output drives power event when status and enable set
// - arbiter grants highest-priority of five requesters, four external plus self
// - arbiter pin remap: grants 1-3 on direction and strobe pins, requests 0-2 on chip selects
module xbus_arbiter_pin_share
    import pin_share_pkg::*;
#(
    parameter int STROBE_CYCLES = 4
) (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic [SDRAM_ADDR_W-1:0] sdram_row_col_address,
    input  wire port_req_type            port_req,
    output logic                         port_ready,
    output logic                         port_done,
    output logic [DATA_W-1:0]            port_rdata,
    output logic [ADDR_W-1:0]            cpu_addr_out,
    output logic [DATA_W-1:0]            cpu_data_out,
    output logic                         cpu_data_oe_n,
    input  wire logic [DATA_W-1:0]       cpu_data_in,
    input  wire logic [NUM_CS-1:0]       cs_dir_out,
    input  wire logic                    pme_out_enable,
    input  wire logic [PMCS_W-1:0]       power_mgmt_ctrl_status,
    input  wire logic [NUM_CS-1:0]       cs_pin_in,
    input  wire logic                    req3_pin_n,
    input  wire logic                    self_req,
    output logic                         self_gnt,
    output logic [NUM_CS-1:0]            cs_irq,
    output logic                         port_mode,
    output pin_drive_type                pins
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release and strap capture

    logic rst_meta_reg, rst_sync_reg, strap_seen_reg;
    logic port_mode_reg;
    logic [NUM_CS-1:0] cs_meta_reg, cs_sync_reg;
    logic req3_meta_reg, req3_sync_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'h0;
            rst_sync_reg <= 1'h0;
        end else begin
            rst_meta_reg <= 1'h1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // strap caught on the first clock after release; pins are inputs until then
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            strap_seen_reg <= 1'h0;
            port_mode_reg  <= STRAP_RESET;
        end else if (!strap_seen_reg) begin
            strap_seen_reg <= 1'h1;
            port_mode_reg  <= sdram_row_col_address[STRAP_BIT];
        end
    end
    assign port_mode = port_mode_reg;

    // pin inputs come from outside: two flops before use
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cs_meta_reg   <= '1;
            cs_sync_reg   <= '1;
            req3_meta_reg <= 1'h1;
            req3_sync_reg <= 1'h1;
        end else begin
            cs_meta_reg   <= cs_pin_in;
            cs_sync_reg   <= cs_meta_reg;
            req3_meta_reg <= req3_pin_n;
            req3_sync_reg <= req3_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peripheral port access sequencer

    function automatic logic [NUM_CS-1:0] cs_decode(input logic [ADDR_W-1:0] a);
        logic [1:0] sel;
        sel = a[CS_SEL_LSB +: 2];
        cs_decode = '0;
        if (sel < 2'(NUM_CS)) begin
            cs_decode[sel] = 1'h1;
        end
    endfunction

    port_state_type state_reg;
    logic [7:0] count_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic wide_reg;
    logic [NUM_CS-1:0] cs_hit_reg;
    logic active;

    assign active     = strap_seen_reg && port_mode_reg;
    assign port_ready = active && (state_reg == PORT_IDLE);

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg  <= PORT_IDLE;
            count_reg  <= 8'h00;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            wide_reg   <= 1'h0;
            cs_hit_reg <= '0;
        end else begin
            unique case (state_reg)
                PORT_IDLE: begin
                    if (port_ready && port_req.valid) begin
                        state_reg  <= port_req.write ? PORT_WRITE : PORT_READ;
                        count_reg  <= 8'(STROBE_CYCLES - 1);
                        addr_reg   <= port_req.addr;
                        wdata_reg  <= port_req.wdata;
                        wide_reg   <= port_req.wide;
                        cs_hit_reg <= cs_decode(port_req.addr);
                    end
                end
                PORT_READ, PORT_WRITE: begin
                    if (count_reg == 8'h00) begin
                        state_reg <= PORT_IDLE;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
            endcase
        end
    end

    // read data captured on the last strobe cycle; 8-bit parts fill the low byte only
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            port_rdata <= '0;
            port_done  <= 1'h0;
        end else begin
            port_done <= (state_reg != PORT_IDLE) && (count_reg == 8'h00);
            if (state_reg == PORT_READ && count_reg == 8'h00) begin
                port_rdata <= wide_reg ? {16'h0000, cpu_data_in[15:0]}
                                       : {24'h000000, cpu_data_in[7:0]};
            end
        end
    end

    assign cpu_addr_out  = addr_reg;
    assign cpu_data_out  = wdata_reg;
    assign cpu_data_oe_n = !(state_reg == PORT_WRITE);

    ////////////////////////////////////////////////////////////////////////////
    // arbiter: fixed priority, request 0 highest, self lowest

    logic [NUM_MASTERS-1:0] req_vec, gnt_reg;

    // chip-select pins are requests here whatever their direction bits say
    assign req_vec = {self_req, ~req3_sync_reg, ~cs_sync_reg};

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            gnt_reg <= '0;
        end else if (!(strap_seen_reg && !port_mode_reg)) begin
            gnt_reg <= '0;
        end else if (!(|(gnt_reg & req_vec))) begin
            gnt_reg <= req_vec & (~req_vec + NUM_MASTERS'(1));
        end
    end

    // the board loop from request to grant returns this to the device's master logic
    assign self_gnt = gnt_reg[NUM_MASTERS-1];

    ////////////////////////////////////////////////////////////////////////////
    // pin drive and interrupt inputs

    logic pme_assert;
    assign pme_assert = power_mgmt_ctrl_status[PME_STATUS_BIT]
                        && power_mgmt_ctrl_status[PME_ENABLE_BIT];

    always_comb begin
        pins.gnt0_n    = 1'h1;
        pins.buf_dir_n = 1'h1;
        pins.rd_n      = 1'h1;
        pins.wr_n      = 1'h1;
        pins.cs_out_n  = '1;
        pins.cs_oe_n   = '1;  // chip-select pins float until the strap is taken; strobes and grant pins held high
        if (active) begin
            pins.buf_dir_n = !(state_reg == PORT_WRITE);
            pins.rd_n      = !(state_reg == PORT_READ);
            pins.wr_n      = !(state_reg == PORT_WRITE);
            pins.cs_oe_n   = ~cs_dir_out;
            pins.cs_out_n  = (state_reg != PORT_IDLE) ? ~cs_hit_reg : '1;
            if (pme_out_enable) begin
                pins.cs_oe_n[PME_CS_INDEX]  = 1'h0;
                pins.cs_out_n[PME_CS_INDEX] = !pme_assert;
            end
        end else if (strap_seen_reg) begin
            pins.gnt0_n    = !gnt_reg[0];
            pins.buf_dir_n = !gnt_reg[1];
            pins.rd_n      = !gnt_reg[2];
            pins.wr_n      = !gnt_reg[3];
        end
    end

    // inputs pass to interrupts only where the pin is not driven out
    assign cs_irq = active ? (~cs_sync_reg & ~cs_dir_out
                    & ~(NUM_CS'(pme_out_enable) << PME_CS_INDEX)) : '0;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // helper: cycles the current strobe has been low, so its length can be judged
    // against the parameter without a long repetition inside a property
    logic [8:0] strobe_len_reg;

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            strobe_len_reg <= 9'h000;
        end else if (active && !(pins.rd_n && pins.wr_n)) begin
            strobe_len_reg <= strobe_len_reg + 9'h001;
        end else begin
            strobe_len_reg <= 9'h000;
        end
    end

    // strobes and buffer direction; direction must follow the write strobe exactly
    a_write_dir_whole: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        active |-> (pins.buf_dir_n == pins.wr_n))
        else $error("buffer direction differs from write strobe");
    a_read_strobe: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        port_ready && port_req.valid && !port_req.write |=> !pins.rd_n)
        else $error("read strobe missing");
    a_write_strobe: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        port_ready && port_req.valid && port_req.write |=> !pins.wr_n && !pins.buf_dir_n)
        else $error("write strobe missing");
    a_strobe_length: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        active && $rose(pins.rd_n && pins.wr_n) |-> strobe_len_reg == 9'(STROBE_CYCLES))
        else $error("strobe length differs from configured count");
    a_no_dir_read: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        !pins.rd_n && active |-> pins.buf_dir_n)
        else $error("buffer direction on read");
    a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        active && (state_reg == PORT_IDLE) |-> pins.rd_n && pins.wr_n && pins.buf_dir_n)
        else $error("strobe active while port idle");

    // selects, completion and power event
    a_done_after: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        port_done |-> $past(!pins.rd_n || !pins.wr_n))
        else $error("done without a preceding strobe");
    a_cs_match: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        active && (state_reg != PORT_IDLE) && !pme_out_enable |->
        (~pins.cs_out_n == cs_decode(cpu_addr_out)))
        else $error("chip select mismatch");
    a_pme_out: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        active && pme_out_enable |-> pins.cs_out_n[PME_CS_INDEX] == !pme_assert)
        else $error("power event pin wrong");

    // pins stay released until the strap is taken, and the mode never moves after
    a_reset_quiet: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        !strap_seen_reg |-> (pins.cs_oe_n == '1) && pins.rd_n && pins.wr_n && pins.gnt0_n)
        else $error("pins driven before strap capture");
    a_strap_held: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        strap_seen_reg && $past(strap_seen_reg) |-> $stable(port_mode_reg))
        else $error("mode changed after capture");

    // arbiter: grant shape, priority, no pre-emption, pin map
    a_grant_onehot: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        $onehot0(gnt_reg) && (!(port_mode_reg && strap_seen_reg) || (gnt_reg == '0)))
        else $error("grant not one-hot");
    a_arb_priority: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        strap_seen_reg && !port_mode_reg && !(|(gnt_reg & req_vec)) && (|req_vec) |=>
        (((gnt_reg - NUM_MASTERS'(1)) & $past(req_vec)) == '0)
        && ((gnt_reg & $past(req_vec)) != '0))
        else $error("grant skipped a higher-priority request");
    a_grant_held: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        strap_seen_reg && !port_mode_reg && (|(gnt_reg & req_vec)) |=> $stable(gnt_reg))
        else $error("grant moved while its request stood");
    a_arb_pins: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        strap_seen_reg && !port_mode_reg |-> pins.cs_oe_n == '1 && pins.rd_n == !gnt_reg[2])
        else $error("arbiter pin map wrong");
    a_cs_as_request: assert property (@(posedge clock) disable iff (!rst_sync_reg)
        strap_seen_reg && !port_mode_reg && !cs_sync_reg[0] && !(|(gnt_reg & req_vec))
        |=> !pins.gnt0_n)
        else $error("chip-select pin not taken as a request");

    // main scenarios the bench is expected to reach
    c_read: cover property (@(posedge clock) disable iff (!rst_sync_reg)
        $fell(pins.rd_n) && active);
    c_write: cover property (@(posedge clock) disable iff (!rst_sync_reg)
        $fell(pins.wr_n) && active);
    c_grant: cover property (@(posedge clock) disable iff (!rst_sync_reg) |gnt_reg);
    c_pme: cover property (@(posedge clock) disable iff (!rst_sync_reg)
        active && pme_out_enable && pme_assert);
    c_self_grant: cover property (@(posedge clock) disable iff (!rst_sync_reg)
        self_gnt && !port_mode_reg);

endmodule

// [testbench/periph_model.sv]
/*
 * far-side model: peripheral chips on the port plus interrupt and request sources.
 * assumes transparent transceivers and pull-ups on released chip-select pins.
 */
`timescale 1ns/1ps
module periph_model
    import pin_share_pkg::*;
#(
    parameter logic [DATA_W-1:0] READ_WORD = 32'h5a5a_c3a1
) (
    input  wire logic              clock,
    input  wire pin_drive_type     pins,
    input  wire logic [NUM_CS-1:0] ext_cs_n,
    output logic [DATA_W-1:0]      cpu_data_in,
    output logic [NUM_CS-1:0]      cs_pin_in
);
    logic [DATA_W-1:0] last_reg = '0;
    logic              reading;

    // a chip drives data only while selected and strobed; else the bus wanders
    assign reading     = !pins.rd_n && (pins.cs_out_n != 3'h7);
    assign cpu_data_in = reading ? READ_WORD : ~last_reg;
    always_ff @(posedge clock) begin
        last_reg <= cpu_data_in;
    end

    // pin level: the device where it drives, else the outside party or pull-up
    assign cs_pin_in = (pins.cs_oe_n & ext_cs_n) | (~pins.cs_oe_n & pins.cs_out_n);
endmodule

// [testbench/test_xbus_arbiter_pin_share.sv]
/*
 * self-checking bench for the shared peripheral-port / arbiter pin group.
 * assumes the far-side model in periph_model and a 50 MHz core clock.
 */
`timescale 1ns/1ps
module test_xbus_arbiter_pin_share;
    import pin_share_pkg::*;
    localparam int STROBES = 3;   // shortened strobe keeps the run brief
    logic                    clock = 1'b0;
    logic                    rst_n = 1'b0;
    logic [SDRAM_ADDR_W-1:0] strap = 13'h1fff;
    port_req_type            port_req = '0;
    logic                    port_ready, port_done, cpu_data_oe_n, self_gnt, port_mode;
    logic [DATA_W-1:0]       port_rdata, cpu_data_out, cpu_data_in;
    logic [ADDR_W-1:0]       cpu_addr_out;
    logic [NUM_CS-1:0]       cs_dir_out = 3'h7;
    logic [NUM_CS-1:0]       ext_cs_n = 3'h7;
    logic [NUM_CS-1:0]       cs_pin_in, cs_irq;
    logic                    pme_out_enable = 1'b0;
    logic [PMCS_W-1:0]       pmcs = '0;
    logic                    req3_pin_n = 1'b1;
    logic                    self_req = 1'b0;
    pin_drive_type           pins;
    int                      bad_count = 0;
    int                      num_checks = 0;
    int                      cycles = 0;

    xbus_arbiter_pin_share #(.STROBE_CYCLES(STROBES)) dut_u (
        .clock(clock), .rst_n(rst_n), .sdram_row_col_address(strap),
        .port_req(port_req), .port_ready(port_ready), .port_done(port_done),
        .port_rdata(port_rdata), .cpu_addr_out(cpu_addr_out),
        .cpu_data_out(cpu_data_out), .cpu_data_oe_n(cpu_data_oe_n),
        .cpu_data_in(cpu_data_in), .cs_dir_out(cs_dir_out),
        .pme_out_enable(pme_out_enable), .power_mgmt_ctrl_status(pmcs),
        .cs_pin_in(cs_pin_in), .req3_pin_n(req3_pin_n), .self_req(self_req),
        .self_gnt(self_gnt), .cs_irq(cs_irq), .port_mode(port_mode), .pins(pins));

    periph_model far_u (.clock(clock), .pins(pins), .ext_cs_n(ext_cs_n),
        .cpu_data_in(cpu_data_in), .cs_pin_in(cs_pin_in));

    initial begin
        forever #10 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one port access; counts cycles where every strobe, select and drive agrees
    task automatic access(input logic wr, input logic wide, input logic [1:0] sel,
                          input logic [31:0] exp_rd);
        logic [ADDR_W-1:0] a;
        int lows, last_low, done_at;
        a = 32'h0000_0010 | (32'(sel) << CS_SEL_LSB);
        lows = 0;
        last_low = 0;
        done_at = 0;
        port_req = '{valid: 1'b1, write: wr, wide: wide, addr: a, wdata: 32'hdead_beef};
        check(port_ready, 1'b1);
        @(negedge clock);
        port_req.valid = 1'b0;
        for (int i = 1; i <= 12 && done_at == 0; i++) begin
            if (port_done === 1'b1) begin
                done_at = i;
            end else if ((wr ? pins.wr_n : pins.rd_n) === 1'b0
                    && (wr ? pins.rd_n : pins.wr_n) === 1'b1 && pins.buf_dir_n === !wr
                    && pins.cs_out_n === ~(3'h1 << sel) && cpu_addr_out === a
                    && (!wr || (cpu_data_oe_n === 1'b0 && cpu_data_out === 32'hdead_beef)))
            begin
                lows++;
                last_low = i;
            end
            @(negedge clock);
        end
        check(lows, STROBES);
        check(done_at, last_low + 1);
        check({port_done, pins.rd_n, pins.wr_n, pins.buf_dir_n, cpu_data_oe_n}, 5'h0f);
        if (!wr) check(port_rdata, exp_rd);
    endtask

    // pin 2 as interrupt input, pins 0 and 1 stay chip-select outputs
    task automatic irq_test();
        cs_dir_out = 3'h3;
        ext_cs_n = 3'h3;
        repeat (5) @(negedge clock);
        check(cs_irq, 3'h4);
        check(pins.cs_oe_n, 3'h4);
        ext_cs_n = 3'h7;
        repeat (5) @(negedge clock);
        check(cs_irq, 3'h0);
    endtask

    // power event on pin 1 needs both status and enable
    task automatic pme_test();
        pme_out_enable = 1'b1;
        pmcs = 16'h8000;
        repeat (3) @(negedge clock);
        check({pins.cs_oe_n[1], pins.cs_out_n[1]}, 2'h1);
        pmcs = 16'h8100;
        repeat (3) @(negedge clock);
        check({pins.cs_oe_n[1], pins.cs_out_n[1]}, 2'h0);
        pmcs = 16'h0100;
        repeat (3) @(negedge clock);
        check(pins.cs_out_n[1], 1'b1);
        pme_out_enable = 1'b0;
        cs_dir_out = 3'h7;
    endtask

    // expected order: self_gnt, grant3, grant2, grant1, grant0 (pin grants active low, self_gnt active high)
    task automatic arb(input logic [2:0] ext, input logic r3_n, input logic [4:0] exp);
        ext_cs_n = ext;
        req3_pin_n = r3_n;
        repeat (7) @(negedge clock);
        // self_gnt stands for the board loop from own request pin back to own grant
        check({self_gnt, pins.wr_n, pins.rd_n, pins.buf_dir_n, pins.gnt0_n}, exp);
        check(pins.cs_oe_n, 3'h7);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
        check(port_mode, 1'b1);
        for (int s = 0; s < 4; s++) access(1'b1, 1'b0, s[1:0], 32'h0);
        access(1'b0, 1'b1, 2'h1, 32'h0000_c3a1);
        access(1'b0, 1'b0, 2'h2, 32'h0000_00a1);
        irq_test();
        pme_test();
        // second reset with the strap low selects the arbiter
        rst_n = 1'b0;
        strap = 13'h1f7f;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
        strap = 13'h1fff;
        repeat (3) @(negedge clock);
        check({port_mode, port_ready}, 2'h0);
        // own request waits until the pin requests are through their synchronisers,
        // since a grant once given is held while its request stands
        arb(3'h2, 1'b0, 5'h0e);
        self_req = 1'b1;
        arb(3'h3, 1'b0, 5'h0b);
        arb(3'h5, 1'b0, 5'h0d);
        arb(3'h7, 1'b0, 5'h07);
        arb(3'h7, 1'b1, 5'h1f);
        self_req = 1'b0;
        arb(3'h7, 1'b1, 5'h0f);
        wrap_up();
    end
endmodule
